// ---- adc_cfg.sv ----
// Purpose: power-down and feature-select registers behind the serial link,
//          plus the output frame builder fed through a sample fifo
// Assumes: link pins are asynchronous to clk_i and sampled here;
//          sclk idles low, data in on rise, data out on fall
// Notes:   one command word per frame; result frame starts on 16th fall
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// sample fifo
// ****************************************************************
module sample_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // draining side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr;        // next slot to fill
  logic [AW-1:0]    rd_ptr;        // next slot to drain
  logic [AW:0]      count;         // words held
  logic [AW:0]      next_count;    // count after this cycle
  logic             push;          // word accepted
  logic             pop;           // word taken

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

  // storage writes, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
    end
  end

  // registered ready: honest full, back-pressure to the source
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_ready_o <= 1'b0;
    end else begin
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // sample_fifo

// How it works
// (RQ1) power-down bit stops front end, skips scan
// (RQ2) four-channel variant: upper bits locked, read ones
// (RQ3) top two bits hold daisy-chain device id
// (RQ4) bit four enables the threshold alarm
// (RQ5) bits five and three read zero
// (RQ6) low three bits select output frame format
// (RQ7) output stream starts on 16th falling edge
// (RQ8) frame bits 26..9 carry result, msb first
// (RQ9) tail fields follow the format code
// (RQ10) channel address is four bits wide
// (RQ11) device address equals configured device id
// (RQ12) range field is low three range bits
// (RQ13) undefined format codes act like code zero
module adc_cfg #(
  parameter int NUM_CHAN   = 8,    // 4 or 8 channel variant
  parameter int FIFO_DEPTH = 16    // sample buffer depth
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // serial link pins
  input  wire logic                 sclk_i,
  input  wire logic                 cs_b_i,
  input  wire logic                 sdi_i,
  output logic                      sdo_o,
  output logic                      sdo_oe_b_o,
  // conversion samples in
  input  wire logic                 smp_valid_i,
  input  wire adc_cfg_pkg::sample_t smp_data_i,
  output logic                      smp_ready_o,
  // configuration out
  output logic [7:0]                frontend_off_o,
  output logic [7:0]                scan_eligible_o,
  output logic                      alarm_en_o
);
  localparam int SW = $bits(adc_cfg_pkg::sample_t);

  // ****************************************************************
  // pin synchronisers and edge finding
  // ****************************************************************
  logic [2:0] sclk_s;   // [0] first stage, read only by [1]
  logic [1:0] cs_s;     // [0] first stage, read only by [1]
  logic [1:0] sdi_s;    // [0] first stage, read only by [1]
  logic       rise;     // sclk rising edge seen
  logic       fall;     // sclk falling edge seen
  logic       active;   // chip select asserted
  logic       cs_prev;  // active one cycle ago

  // two flops per pin, third sclk flop for edges
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sclk_s <= '0;
      cs_s   <= 2'h3;
      sdi_s  <= '0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      cs_s   <= {cs_s[0], cs_b_i};
      sdi_s  <= {sdi_s[0], sdi_i};
    end
  end
  assign rise   = sclk_s[1] && !sclk_s[2];
  assign fall   = !sclk_s[1] && sclk_s[2];
  assign active = !cs_s[1];

  // ****************************************************************
  // frame counters and command capture
  // ****************************************************************
  logic [5:0]                   rise_cnt;   // rising edges this frame
  logic [5:0]                   fall_cnt;   // falling edges this frame
  logic [adc_cfg_pkg::CMD_BITS-1:0] cmd_sh; // command shift in
  adc_cfg_pkg::cmd_t            cmd;        // completed command
  logic                         cmd_done;   // pulse at 16th rise
  logic                         frame_go;   // pulse on frame start

  assign cmd_done = active && rise && (rise_cnt == adc_cfg_pkg::LAST_CMD);
  assign frame_go = active && !cs_prev;

  // edge counters, cleared while deselected
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !active) begin
      rise_cnt <= '0;
      fall_cnt <= '0;
    end else begin
      if (rise && rise_cnt != adc_cfg_pkg::EDGE_MAX) rise_cnt <= rise_cnt + 1'b1;
      if (fall && fall_cnt != adc_cfg_pkg::EDGE_MAX) fall_cnt <= fall_cnt + 1'b1;
    end
  end

  // command word shifts in msb first on sclk rise
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmd_sh  <= '0;
      cmd     <= '0;
      cs_prev <= 1'b0;
    end else begin
      cs_prev <= active;
      if (active && rise) cmd_sh <= {cmd_sh[14:0], sdi_s[1]};
      if (cmd_done) cmd <= adc_cfg_pkg::cmd_t'({cmd_sh[14:0], sdi_s[1]});
    end
  end

  // ****************************************************************
  // program registers
  // ****************************************************************
  logic [7:0] chan_pd;      // channel_frontend_powerdown
  logic [7:0] feature_sel;  // feature_select
  logic [7:0] lock_mask;    // bits a write may not touch
  logic [7:0] pd_read;      // power-down as the host reads it
  adc_cfg_pkg::cmd_t wcmd;  // command being completed

  assign wcmd      = adc_cfg_pkg::cmd_t'({cmd_sh[14:0], sdi_s[1]});
  assign lock_mask = (NUM_CHAN == 4) ? adc_cfg_pkg::UPPER_CHANS : 8'h00;
  assign pd_read   = chan_pd | lock_mask;   // see (RQ2)

  // writes land at the 16th rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      chan_pd     <= adc_cfg_pkg::PD_RESET;   // see (RQ1)
      feature_sel <= adc_cfg_pkg::FS_RESET;   // see (RQ3) (RQ4) (RQ6)
    end else if (cmd_done && wcmd.wr) begin
      if (wcmd.addr == adc_cfg_pkg::ADDR_CHAN_PD) begin
        // locked upper bits keep their zero, see (RQ2)
        chan_pd <= wcmd.data & ~lock_mask;
      end
      if (wcmd.addr == adc_cfg_pkg::ADDR_FEATURE) begin
        // reserved bits dropped whatever the host sends, see (RQ5)
        feature_sel <= wcmd.data & adc_cfg_pkg::FS_WRITE_MASK;
      end
    end
  end

  // configuration outputs, one flop each
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      frontend_off_o  <= '0;
      scan_eligible_o <= '0;
      alarm_en_o      <= 1'b0;
    end else begin
      frontend_off_o  <= chan_pd;                           // see (RQ1)
      scan_eligible_o <= ~chan_pd & ~lock_mask;             // see (RQ1)
      alarm_en_o      <= feature_sel[adc_cfg_pkg::FS_ALARM]; // see (RQ4)
    end
  end

  // ****************************************************************
  // sample buffer and current sample
  // ****************************************************************
  logic                 fifo_valid;  // a sample waits
  logic [SW-1:0]        fifo_data;   // oldest sample
  adc_cfg_pkg::sample_t cur;         // sample for this frame

  sample_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (smp_valid_i),
    .in_data_i   (smp_data_i),
    .in_ready_o  (smp_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (frame_go)
  );

  // one sample taken per frame; empty buffer gives zeros
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else if (frame_go) begin
      cur <= fifo_valid ? adc_cfg_pkg::sample_t'(fifo_data) : '0;
    end
  end

  // ****************************************************************
  // output frame builder
  // ****************************************************************
  logic [2:0]                       eff_fmt;   // format actually used
  logic [adc_cfg_pkg::TAIL_BITS-1:0] tail;     // bits 8..0
  logic [adc_cfg_pkg::OUT_BITS-1:0]  out_word; // bits 26..0
  logic [7:0]                       rd_data;  // register read value
  logic                             reg_rd;   // frame is a register read
  logic                             load;     // 16th falling edge
  logic [adc_cfg_pkg::OUT_BITS-1:0]  out_sh;   // outgoing shift register

  // undefined codes fall back to the plain frame, see (RQ13)
  assign eff_fmt = feature_sel[adc_cfg_pkg::FS_FMT_HI] ?
                   adc_cfg_pkg::FMT_PLAIN : feature_sel[2:0];
  assign reg_rd  = !cmd.wr && (cmd.addr == adc_cfg_pkg::ADDR_CHAN_PD ||
                               cmd.addr == adc_cfg_pkg::ADDR_FEATURE);
  assign rd_data = (cmd.addr == adc_cfg_pkg::ADDR_CHAN_PD) ? pd_read :
                   feature_sel;
  assign load    = active && fall && (fall_cnt == adc_cfg_pkg::START_FALL);

  // tail fields by format, low bits default to zero, see (RQ9)
  always_comb begin
    tail = '0;
    case (eff_fmt)
      adc_cfg_pkg::FMT_CHAN:  tail = {cur.chan, 5'h00};            // see (RQ10)
      adc_cfg_pkg::FMT_DEV:   tail = {cur.chan,
        feature_sel[adc_cfg_pkg::FS_DEV_HI:adc_cfg_pkg::FS_DEV_LO],
        3'h0};                                                    // see (RQ11)
      adc_cfg_pkg::FMT_RANGE: tail = {cur.chan,
        feature_sel[adc_cfg_pkg::FS_DEV_HI:adc_cfg_pkg::FS_DEV_LO],
        cur.range};                                               // see (RQ12)
      default:                tail = '0;
    endcase
    // register reads return the byte in place of the result
    out_word = reg_rd ? {rd_data, 19'h0_0000} : {cur.result, tail}; // see (RQ8)
  end

  // shift out from the 16th falling edge, low before that, see (RQ7)
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !active) begin
      out_sh <= '0;
      sdo_o  <= 1'b0;
    end else if (load) begin
      out_sh <= {out_word[25:0], 1'b0};
      sdo_o  <= out_word[26];
    end else if (fall && fall_cnt > adc_cfg_pkg::START_FALL) begin
      out_sh <= {out_sh[25:0], 1'b0};
      sdo_o  <= out_sh[26];
    end
  end

  // pin driven only while selected, enable is active low
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sdo_oe_b_o <= 1'b1;
    end else begin
      sdo_oe_b_o <= !active;
    end
  end

  // ****************************************************************
  // assertions and covers
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // own disable: the default one would switch this check off entirely
  a_reset_values: assert property (disable iff (1'b0) !rst_b_i |=>
    chan_pd == adc_cfg_pkg::PD_RESET && feature_sel == adc_cfg_pkg::FS_RESET)
    else $error("registers not cleared"); // see (RQ1)
  a_upper_locked: assert property (NUM_CHAN == 4 |-> chan_pd[7:4] == 4'h0 &&
    pd_read[7:4] == 4'hf) else $error("upper channels changed"); // see (RQ2)
  a_reserved_zero: assert property (feature_sel[5] == 1'b0 &&
    feature_sel[3] == 1'b0) else $error("reserved bit set"); // see (RQ5)
  a_scan_follows: assert property (cmd_done && wcmd.wr &&
    wcmd.addr == adc_cfg_pkg::ADDR_CHAN_PD && NUM_CHAN == 8 |-> ##2
    frontend_off_o == $past(wcmd.data, 2) &&
    scan_eligible_o == ~frontend_off_o) else $error("pd not applied"); // see (RQ1)
  a_alarm_follows: assert property (cmd_done && wcmd.wr &&
    wcmd.addr == adc_cfg_pkg::ADDR_FEATURE |-> ##2
    alarm_en_o == $past(wcmd.data[4], 2)) else $error("alarm enable lag"); // see (RQ4)
  a_stream_start: assert property (load |=> sdo_o == $past(out_word[26]))
    else $error("stream did not start"); // see (RQ7)
  a_quiet_before: assert property (active && fall_cnt < adc_cfg_pkg::START_FALL
    |-> sdo_o == 1'b0) else $error("sdo early"); // see (RQ7)
  a_tail_plain: assert property (load && !reg_rd && feature_sel[2] |->
    out_word[8:0] == 9'h000) else $error("undefined fmt tail"); // see (RQ13)
  a_tail_dev: assert property (load && !reg_rd && eff_fmt == 3'h2 |->
    out_word[4:3] == feature_sel[7:6] && out_word[8:5] == cur.chan &&
    out_word[2:0] == 3'h0) else $error("device tail wrong"); // see (RQ9)
  a_oe_idle: assert property (!active |=> sdo_oe_b_o)
    else $error("sdo driven idle");

  c_fs_write: cover property (cmd_done && wcmd.wr &&
    wcmd.addr == adc_cfg_pkg::ADDR_FEATURE);
  c_range_frame: cover property (load && !reg_rd && eff_fmt == 3'h3);
  c_reg_read: cover property (load && reg_rd);
  c_fifo_full: cover property (!smp_ready_o);
endmodule // adc_cfg

`default_nettype wire

// ---- adc_cfg_pkg.sv ----
// Purpose: shared constants and carriers for the channel configuration block
// Assumes: 8-bit program registers, 16-bit command word, 27-bit output frame
// Notes:   offsets, program-register reset values and the id, alarm and format-top bit positions live here
`default_nettype none

package adc_cfg_pkg;

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam logic [6:0] ADDR_CHAN_PD  = 7'h02;   // channel front-end off
  localparam logic [6:0] ADDR_FEATURE  = 7'h03;   // feature select
  localparam logic [7:0] PD_RESET      = 8'h00;   // all front ends powered
  localparam logic [7:0] FS_RESET      = 8'h00;   // id 0, alarm off, fmt 0
  localparam logic [7:0] FS_WRITE_MASK = 8'hd7;   // bits 5 and 3 stay zero
  localparam logic [7:0] UPPER_CHANS   = 8'hf0;   // channels four to seven
  localparam int         FS_DEV_HI     = 7;       // device id, top bit
  localparam int         FS_DEV_LO     = 6;       // device id, low bit
  localparam int         FS_ALARM      = 4;       // alarm enable
  localparam int         FS_FMT_HI     = 2;       // frame format, top bit

  // ****************************************************************
  // frame format codes
  // ****************************************************************
  localparam logic [2:0] FMT_PLAIN = 3'h0;   // result, tail low
  localparam logic [2:0] FMT_CHAN  = 3'h1;   // plus channel address
  localparam logic [2:0] FMT_DEV   = 3'h2;   // plus device address
  localparam logic [2:0] FMT_RANGE = 3'h3;   // plus input range

  // ****************************************************************
  // link framing
  // ****************************************************************
  localparam int         CMD_BITS   = 16;      // command word length
  localparam int         OUT_BITS   = 27;      // output frame bits 26..0
  localparam int         TAIL_BITS  = 9;       // bits 8..0 after result
  localparam logic [5:0] LAST_CMD   = 6'h0f;   // index of 16th rising edge
  localparam logic [5:0] START_FALL = 6'h0f;   // index of 16th falling edge
  localparam logic [5:0] EDGE_MAX   = 6'h3f;   // counters saturate here

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [17:0] result;   // conversion result, msb first
    logic [3:0]  chan;     // channel address
    logic [2:0]  range;    // low bits of range code
  } sample_t;

  typedef struct packed {
    logic [6:0] addr;      // register address
    logic       wr;        // 1 = write
    logic [7:0] data;      // write data
  } cmd_t;

endpackage

`default_nettype wire

// ---- host_link_model.sv ----
// Purpose: host side of the serial link; sends frames, captures sdo
// Assumes: sclk idles low, 160 ns period, pins move on falling clk_i
// Notes:   two sdo lines are captured so both variants share one frame
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // clock
  input  wire logic       clk_i,
  // link pins
  output logic            sclk_o,
  output logic            cs_b_o,
  output logic            sdi_o,
  input  wire logic [1:0] sdo_i,
  input  wire logic [1:0] sdo_oe_b_i
);
  // ****************************************************************
  // frame driver
  // ****************************************************************
  localparam int HALF = 20;   // half sclk period in clk_i cycles

  // idle link: deselected, clock low
  initial begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // command msb first on rises; reply bits read just before each rise
  task automatic frame(input logic [15:0] cmd, input int n_cyc,
                       output logic [1:0][26:0] rsp, output logic oe_bad);
    rsp    = '0;
    oe_bad = 1'b0;
    @(negedge clk_i);
    cs_b_o = 1'b0;
    for (int i = 0; i < n_cyc; i++) begin
      sdi_o = (i < 16) ? cmd[15-i] : 1'b0;
      repeat (HALF) @(negedge clk_i);
      oe_bad = oe_bad | sdo_oe_b_i[0];
      // reply starts after the 16th fall
      if (i >= 16) begin
        rsp[0][42-i] = sdo_i[0];
        rsp[1][42-i] = sdo_i[1];
      end
      sclk_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge clk_i);
    cs_b_o = 1'b1;
    // deselect gap well over the three-cycle minimum
    repeat (8) @(negedge clk_i);
  endtask
endmodule // host_link_model
`default_nettype wire

// ---- adc_channel_pd_and_output_format_test.sv ----
// Purpose: self-checking bench for the channel configuration block
// Assumes: host model drives the link; samples pushed by this bench
// Notes:   a four-channel copy shares the link pins to show locked bits
`timescale 1ns/1ps
`default_nettype none
module adc_channel_pd_and_output_format_test;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                  clk_i;       // 250 MHz
  logic                  rst_b_i;     // sync, active low
  logic                  sclk, cs_b, sdi;
  logic [1:0]            sdo, oe_b;   // [0] eight, [1] four channels
  logic                  smp_valid, smp_ready, alarm8, alarm4;
  adc_cfg_pkg::sample_t  smp_data;
  logic [7:0]            off8, elig8, off4, elig4;
  logic [1:0][26:0]      r;           // last captured reply
  int                    bad_count, check_count;

  always #2 clk_i = ~clk_i;

  // ****************************************************************
  // instances
  // ****************************************************************
  adc_cfg #(.NUM_CHAN(8)) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
    .sdi_i(sdi), .sdo_o(sdo[0]), .sdo_oe_b_o(oe_b[0]),
    .smp_valid_i(smp_valid), .smp_data_i(smp_data),
    .smp_ready_o(smp_ready), .frontend_off_o(off8),
    .scan_eligible_o(elig8), .alarm_en_o(alarm8));
  // same sample stream: both buffers pop in step, so frames must agree
  adc_cfg #(.NUM_CHAN(4)) dut4_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_b_i(cs_b),
    .sdi_i(sdi), .sdo_o(sdo[1]), .sdo_oe_b_o(oe_b[1]),
    .smp_valid_i(smp_valid), .smp_data_i(smp_data), .smp_ready_o(),
    .frontend_off_o(off4), .scan_eligible_o(elig4), .alarm_en_o(alarm4));
  host_link_model link_u (
    .clk_i(clk_i), .sclk_o(sclk), .cs_b_o(cs_b), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_b_i(oe_b));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one frame; writes stop after the command word
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [7:0] d);
    logic bad;
    link_u.frame({a, w, d}, w ? 16 : 43, r, bad);
    check(27'(bad), 27'h0);
    check(27'({oe_b, sdo}), 27'hc);
  endtask

  // register read on both variants
  task automatic rd(input logic [6:0] a, input logic [7:0] e8,
                    input logic [7:0] e4);
    xfer(a, 1'b0, 8'h00);
    check(r[0], {e8, 19'h0});
    check(r[1], {e4, 19'h0});
  endtask

  // valid held until ready seen; bounded wait
  task automatic push(input adc_cfg_pkg::sample_t s);
    int n;
    n = 0;
    @(negedge clk_i);
    smp_valid = 1'b1;
    smp_data  = s;
    while (smp_ready !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 100) begin
      bad_count++;
      print_verdict();
    end
    @(negedge clk_i);
    smp_valid = 1'b0;
  endtask

  task automatic do_reset;
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check(27'({off8, elig8, elig4}), 27'h00_ff0f);
    check(27'({alarm8, smp_ready}), 27'h1);
    rd(adc_cfg_pkg::ADDR_CHAN_PD, 8'h00, 8'hf0);
    rd(adc_cfg_pkg::ADDR_FEATURE, 8'h00, 8'h00);
    $display("test reset done");
  endtask

  // ****************************************************************
  // format rows: written, read back, alarm, frame bits 8..0
  // ****************************************************************
  typedef struct packed {
    logic [7:0] wr_val;
    logic [7:0] rd_val;
    logic       alarm;
    logic [8:0] tail;
  } row_t;
  row_t rows [9] = '{
    '{8'h00, 8'h00, 1'b0, 9'h000}, '{8'h01, 8'h01, 1'b0, 9'h0a0},
    '{8'h42, 8'h42, 1'b0, 9'h0a8}, '{8'hd3, 8'hd3, 1'b1, 9'h0be},
    '{8'h2c, 8'h04, 1'b0, 9'h000}, '{8'h95, 8'h95, 1'b1, 9'h000},
    '{8'hbe, 8'h96, 1'b1, 9'h000}, '{8'h47, 8'h47, 1'b0, 9'h000},
    '{8'h83, 8'h83, 1'b0, 9'h0b6}};  // rows 2c and be write bits 5,3 on purpose

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] pdv [2];
    pdv = '{8'ha5, 8'h5a};
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    smp_valid = 1'b0;
    smp_data = '0;
    bad_count = 0;
    check_count = 0;
    do_reset();
    // table loop: each format code, then an unmapped read frame
    foreach (rows[i]) begin
      xfer(adc_cfg_pkg::ADDR_FEATURE, 1'b1, rows[i].wr_val);
      check(27'({alarm8, alarm4}), 27'({2{rows[i].alarm}}));
      rd(adc_cfg_pkg::ADDR_FEATURE, rows[i].rd_val,
         rows[i].rd_val);
      push('{18'h2_a5c3, 4'h5, 3'h6});
      xfer(7'h10, 1'b0, 8'h00);
      check(r[0], {18'h2_a5c3, rows[i].tail});
      check(r[1], {18'h2_a5c3, rows[i].tail});
    end
    $display("test formats done");
    // power-down pattern and its inverse on both variants
    foreach (pdv[i]) begin
      xfer(adc_cfg_pkg::ADDR_CHAN_PD, 1'b1, pdv[i]);
      check(27'({off8, elig8}), 27'({pdv[i], ~pdv[i]}));
      check(27'({off4, elig4}),
            27'({4'h0, pdv[i][3:0], 4'h0, ~pdv[i][3:0]}));
      rd(adc_cfg_pkg::ADDR_CHAN_PD, pdv[i],
         {4'hf, pdv[i][3:0]});
    end
    $display("test power-down done");
    do_reset();
    // fill the buffer until refused, then drain one per frame
    xfer(adc_cfg_pkg::ADDR_FEATURE, 1'b1, 8'h43);
    for (int i = 0; i < 16; i++) begin
      push('{18'(i * 3001), 4'(i % 8), 3'(i)});
    end
    repeat (2) @(negedge clk_i);
    check(27'(smp_ready), 27'h0);
    for (int i = 0; i < 17; i++) begin
      xfer(7'h10, 1'b0, 8'h00);
      check(r[0], i < 16 ? {18'(i * 3001), 4'(i % 8), 2'b01, 3'(i)}
                         : 27'h8);
    end
    check(27'(smp_ready), 27'h1);
    $display("test buffer done");
    print_verdict();
  end
endmodule // adc_channel_pd_and_output_format_test
`default_nettype wire
